// >>> sdl_regs.svh
// constants of the serial converter load interface
// assumes inclusion by its bare name from package and top module
`ifndef SDL_REGS_SVH
`define SDL_REGS_SVH

// frame and code layout
`define SDL_FRAME_BITS   24
`define SDL_FRAME_MSB    23
`define SDL_CODE_BITS    18
`define SDL_CODE_MSB     17
`define SDL_PAD_BITS     6
`define SDL_CNT_BITS     5
`define SDL_CNT_FULL     5'h18

// reset values of input register and output latch
`define SDL_RST_VAL_LOW  18'h00000
`define SDL_RST_VAL_HIGH 18'h20000

// data buffer shape
`define SDL_FIFO_DEPTH   8
`define SDL_FIFO_PTR_W   3
`define SDL_FIFO_CNT_W   4

// timing: system clock period and link clock period, in ns
`define SDL_SYS_PERIOD_NS   40
`define SDL_LINK_PERIOD_NS  320
`define SDL_SAMPLES_PER_BIT (`SDL_LINK_PERIOD_NS / `SDL_SYS_PERIOD_NS)

`endif

// >>> sdl_pkg.sv
// types shared by the serial converter load interface
// assumes sdl_regs.svh is on the include path
`include "sdl_regs.svh"

package sdl_pkg;

    // serial link pins, sampled together
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } sdl_link_type;

    // static and slow control pins
    typedef struct packed {
        logic hw_reset_n;
        logic reset_level_select;
        logic code_format_select;
        logic readout_mode_select;
        logic latch_load_n;
    } sdl_ctrl_type;

    typedef logic [`SDL_CODE_MSB:0]  sdl_code_type;
    typedef logic [`SDL_FRAME_MSB:0] sdl_word_type;

    typedef enum logic [0:0] {
        SDL_IDLE   = 1'b0,
        SDL_ACTIVE = 1'b1
    } sdl_state_type;

endpackage

// >>> sdl_sync.sv
// two-stage synchroniser, one per bit
// assumes inputs asynchronous to sys_clk; no reset on data stages
`timescale 1ns/100ps
`default_nettype none

module sdl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always_comb begin
                meta_d[gi] = clk_en ? async_in[gi] : meta_q[gi];
                sync_d[gi] = clk_en ? meta_q[gi] : sync_out[gi];
            end
            always_ff @(posedge sys_clk) begin
                meta_q[gi]   <= meta_d[gi];
                sync_out[gi] <= sync_d[gi];
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> sdl_fifo.sv
// frame buffer: storage array plus a registered output stage
// assumes same clock as the filler and the drainer
`timescale 1ns/100ps
`default_nettype none

module sdl_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3,
    parameter int CNT_W = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             out_valid_d;
    logic [WIDTH-1:0] out_data_d;
    logic             push;
    logic             load;

    always_comb begin
        in_ready    = (cnt_q != CNT_W'(DEPTH));
        push        = in_valid && in_ready;
        load        = (cnt_q != '0) && (!out_valid || out_ready);
        wr_ptr_d    = push ? wr_ptr_q + PTR_W'(1) : wr_ptr_q;
        rd_ptr_d    = load ? rd_ptr_q + PTR_W'(1) : rd_ptr_q;
        cnt_d       = cnt_q + CNT_W'(push) - CNT_W'(load);
        out_valid_d = load ? 1'b1 : (out_valid && !out_ready);
        out_data_d  = load ? mem_q[rd_ptr_q] : out_data;
        if (flush) begin
            wr_ptr_d    = '0;
            rd_ptr_d    = '0;
            cnt_d       = '0;
            out_valid_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            cnt_q     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (clk_en) begin
            wr_ptr_q  <= wr_ptr_d;
            rd_ptr_q  <= rd_ptr_d;
            cnt_q     <= cnt_d;
            out_valid <= out_valid_d;
            out_data  <= out_data_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && push && !flush) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

endmodule

`default_nettype wire

// >>> sdl_top.sv
// serial load front end of an 18-bit voltage-output converter
// assumes link pins asynchronous to sys_clk, link clock at most sys/8
//
// Functional notes
// - hardware reset low forces input register and latch to selected value
// - after hardware reset release, reset value holds until a valid frame
// - power-on reset loads input register and latch with selected value
// - reset value is 00000h for select low, 20000h for select high
// - each frame shifts a 24-bit word on serial clock while selected
// - chip select high ignores clock and data, data out released
// - chip select low samples data in on every rising clock edge
// - frames under 24 bits are dropped; registers keep prior data
// - frames over 24 bits keep only the last 24 bits
// - chip select rising edge after valid frame loads input register
// - bits 23 to 18 ignored; bits 17 to 0 form the code
// - readback mode shifts input register out while new word comes in
// - readback beyond 24 clocks sends register then zeroes
// - mode select low gives chained mode, data out feeds next device
// - chained mode ripples extra bits out, changing on falling edges
// - load pin high holds latch; low makes latch follow input register
// - load pin tied low updates latch as soon as frame is written
// - load pin high during write holds latch until pin goes low
// - resets never clear the serial shift register
// - format select high means straight binary, low twos complement
`timescale 1ns/100ps
`default_nettype none
`include "sdl_regs.svh"

module sdl_top
    import sdl_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic         cs_n,
    input  wire logic         sclk,
    input  wire logic         sdi,
    input  wire logic         hw_reset_n,
    input  wire logic         reset_level_select,
    input  wire logic         code_format_select,
    input  wire logic         readout_mode_select,
    input  wire logic         latch_load_n,
    output logic              sdo_out,
    output logic              sdo_oe_n,
    output logic [17:0]       dac_code,
    output logic              code_is_binary,
    output logic              frame_buf_ready,
    output logic              frame_done,
    output logic              frame_short,
    output logic              frame_dropped
);

    // synchronised pins
    sdl_link_type  link_raw;
    sdl_link_type  link_s;
    sdl_ctrl_type  ctrl_raw;
    sdl_ctrl_type  ctrl_s;

    // link edge tracking
    logic          sclk_prev_q, sclk_prev_d;
    logic          cs_prev_q, cs_prev_d;
    logic          sclk_rise;
    logic          sclk_fall;
    logic          cs_fall;
    logic          cs_rise;

    // frame state
    sdl_state_type state_q, state_d;
    sdl_word_type  shift_q, shift_d;
    sdl_word_type  rb_q, rb_d;
    logic [`SDL_CNT_BITS-1:0] cnt_q, cnt_d;
    logic          sdo_d;
    logic          sdo_oe_n_d;
    logic          readback;

    // buffer handshake
    logic          push_valid;
    logic          push_ready;
    logic          pop_valid;
    logic          pop_ready;
    sdl_code_type  pop_data;

    // storage
    sdl_code_type  in_reg_q, in_reg_d;
    sdl_code_type  latch_d;
    sdl_code_type  reset_value;
    logic          hold_reset;
    logic          done_d;
    logic          short_d;
    logic          dropped_d;
    logic          buf_ready_d;
    logic          binary_d;

    always_comb begin
        link_raw.cs_n                = cs_n;
        link_raw.sclk                = sclk;
        link_raw.sdi                 = sdi;
        ctrl_raw.hw_reset_n          = hw_reset_n;
        ctrl_raw.reset_level_select  = reset_level_select;
        ctrl_raw.code_format_select  = code_format_select;
        ctrl_raw.readout_mode_select = readout_mode_select;
        ctrl_raw.latch_load_n        = latch_load_n;
    end

    sdl_sync #(
        .WIDTH    ($bits(sdl_link_type))
    ) u_link_sync (
        .sys_clk  (sys_clk),
        .clk_en   (clk_en),
        .async_in (link_raw),
        .sync_out (link_s)
    );

    sdl_sync #(
        .WIDTH    ($bits(sdl_ctrl_type))
    ) u_ctrl_sync (
        .sys_clk  (sys_clk),
        .clk_en   (clk_en),
        .async_in (ctrl_raw),
        .sync_out (ctrl_s)
    );

    // edge detection on synchronised link pins
    always_comb begin
        sclk_prev_d = link_s.sclk;
        cs_prev_d   = link_s.cs_n;
        sclk_rise   = link_s.sclk && !sclk_prev_q;
        sclk_fall   = !link_s.sclk && sclk_prev_q;
        cs_fall     = !link_s.cs_n && cs_prev_q;
        cs_rise     = link_s.cs_n && !cs_prev_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else if (clk_en) begin
            sclk_prev_q <= sclk_prev_d;
            cs_prev_q   <= cs_prev_d;
        end
    end

    // frame sequencing, shift and serial data out
    always_comb begin
        readback   = ctrl_s.readout_mode_select;
        state_d    = state_q;
        shift_d    = shift_q;
        rb_d       = rb_q;
        cnt_d      = cnt_q;
        sdo_d      = sdo_out;
        sdo_oe_n_d = sdo_oe_n;
        push_valid = 1'b0;
        short_d    = 1'b0;
        unique case (state_q)
            SDL_IDLE: begin
                sdo_oe_n_d = 1'b1;
                if (cs_fall) begin
                    state_d    = SDL_ACTIVE;
                    cnt_d      = '0;
                    rb_d       = {`SDL_PAD_BITS'h00, in_reg_q};
                    sdo_oe_n_d = 1'b0;
                    sdo_d      = readback ? 1'b0 : shift_q[`SDL_FRAME_MSB];
                end
            end
            SDL_ACTIVE: begin
                if (cs_rise) begin
                    state_d    = SDL_IDLE;
                    sdo_oe_n_d = 1'b1;
                    push_valid = (cnt_q == `SDL_CNT_FULL);
                    short_d    = (cnt_q != `SDL_CNT_FULL);
                end else if (sclk_rise) begin
                    // last 24 bits survive a long frame
                    shift_d = {shift_q[`SDL_FRAME_MSB-1:0], link_s.sdi};
                    if (cnt_q != `SDL_CNT_FULL) begin
                        cnt_d = cnt_q + `SDL_CNT_BITS'(1);
                    end
                end else if (sclk_fall) begin
                    if (readback) begin
                        // register content first, zeroes after
                        sdo_d = rb_q[`SDL_FRAME_MSB-1];
                        rb_d  = {rb_q[`SDL_FRAME_MSB-1:0], 1'b0};
                    end else begin
                        sdo_d = shift_q[`SDL_FRAME_MSB];
                    end
                end
            end
        endcase
    end

    // shift register has no reset on purpose
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            shift_q <= shift_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q  <= SDL_IDLE;
            rb_q     <= '0;
            cnt_q    <= '0;
            sdo_out  <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else if (clk_en) begin
            state_q  <= state_d;
            rb_q     <= rb_d;
            cnt_q    <= cnt_d;
            sdo_out  <= sdo_d;
            sdo_oe_n <= sdo_oe_n_d;
        end
    end

    // frame buffer between shift register and input register
    sdl_fifo #(
        .WIDTH     (`SDL_CODE_BITS),
        .DEPTH     (`SDL_FIFO_DEPTH),
        .PTR_W     (`SDL_FIFO_PTR_W),
        .CNT_W     (`SDL_FIFO_CNT_W)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .flush     (hold_reset),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (shift_q[`SDL_CODE_MSB:0]),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // input register, output latch and status
    always_comb begin
        hold_reset  = !ctrl_s.hw_reset_n;
        reset_value = ctrl_s.reset_level_select ? `SDL_RST_VAL_HIGH
                                                : `SDL_RST_VAL_LOW;
        // readback frame in flight keeps the register steady
        pop_ready   = !(state_q == SDL_ACTIVE && readback);
        in_reg_d    = in_reg_q;
        latch_d     = dac_code;
        if (pop_valid && pop_ready) begin
            in_reg_d = pop_data;
        end
        if (!ctrl_s.latch_load_n) begin
            latch_d = in_reg_q;
        end
        if (hold_reset) begin
            in_reg_d = reset_value;
            latch_d  = reset_value;
        end
        done_d      = push_valid && push_ready;
        dropped_d   = push_valid && !push_ready;
        buf_ready_d = push_ready;
        binary_d    = ctrl_s.code_format_select;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            in_reg_q        <= reset_value;
            dac_code        <= reset_value;
            frame_done      <= 1'b0;
            frame_short     <= 1'b0;
            frame_dropped   <= 1'b0;
            frame_buf_ready <= 1'b0;
            code_is_binary  <= 1'b0;
        end else if (clk_en) begin
            in_reg_q        <= in_reg_d;
            dac_code        <= latch_d;
            frame_done      <= done_d;
            frame_short     <= short_d;
            frame_dropped   <= dropped_d;
            frame_buf_ready <= buf_ready_d;
            code_is_binary  <= binary_d;
        end
    end

endmodule

`default_nettype wire

// >>> sdl_host.sv
// host serial controller model driving the link pins
// assumes the link is idle low on sclk and frames are called one at a time
`timescale 1ns/100ps
`default_nettype none

module sdl_host (
    output logic        cs_n,
    output logic        sclk,
    output logic        sdi,
    input  wire logic   sdo_out,
    input  wire logic   sdo_oe_n,
    output logic [23:0] rx_word
);
    localparam int HALF = 160;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        rx_word = 24'h000000;
    end

    // one frame of n bits of w, msb first; sclk stands still outside frames
    task automatic send(input logic [31:0] w, input int n);
        cs_n = 1'b0;
        #HALF;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #HALF sclk = 1'b1;
            rx_word = {rx_word[22:0], sdo_oe_n ? ~sdo_out : sdo_out};
            #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        sdi = ~sdi;
        #(HALF * 3);
    endtask
endmodule

`default_nettype wire

// >>> sdl_top_asserts.sv
// checker of the serial load front end, bound to sdl_top
// assumes sys_clk rising edge, rst_b active low, clk_en low only briefly
`timescale 1ns/100ps
`default_nettype none

module sdl_top_chk (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        cs_n,
    input wire logic        sclk,
    input wire logic        hw_reset_n,
    input wire logic        reset_level_select,
    input wire logic        code_format_select,
    input wire logic        latch_load_n,
    input wire logic        sdo_out,
    input wire logic        sdo_oe_n,
    input wire logic [17:0] dac_code,
    input wire logic        code_is_binary,
    input wire logic        frame_done,
    input wire logic        frame_short
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_por;
        disable iff (1'b0) (!rst_b)[*4] |->
            dac_code == (reset_level_select ? 18'h20000 : 18'h00000);
    endproperty
    a_por: assert property (p_por) else $error("bad power-on value");
    property p_hwr;
        (!hw_reset_n && $stable(reset_level_select))[*4] |->
            dac_code == (reset_level_select ? 18'h20000 : 18'h00000);
    endproperty
    a_hwr: assert property (p_hwr) else $error("bad reset value");
    property p_hold;
        (latch_load_n && hw_reset_n)[*5] |-> $stable(dac_code);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved");
    property p_fall;
        $changed(sdo_out) && !sdo_oe_n && !$past(sdo_oe_n) |->
            !sclk && !$past(sclk);
    endproperty
    a_fall: assert property (p_fall) else $error("sdo off falling");
    property p_off;
        cs_n[*4] |-> sdo_oe_n;
    endproperty
    a_off: assert property (p_off) else $error("sdo driven idle");
    property p_on;
        (!cs_n)[*4] |-> !sdo_oe_n;
    endproperty
    a_on: assert property (p_on) else $error("sdo not driven");
    property p_fmt;
        ($stable(code_format_select))[*4] |->
            code_is_binary == code_format_select;
    endproperty
    a_fmt: assert property (p_fmt) else $error("format flag wrong");
    property p_done;
        frame_done |-> cs_n && !frame_short;
    endproperty
    a_done: assert property (p_done) else $error("done while selected");
endmodule

bind sdl_top sdl_top_chk u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk),
    .hw_reset_n(hw_reset_n), .reset_level_select(reset_level_select),
    .code_format_select(code_format_select), .latch_load_n(latch_load_n),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .dac_code(dac_code),
    .code_is_binary(code_is_binary), .frame_done(frame_done),
    .frame_short(frame_short)
);

`default_nettype wire

// >>> tb.sv
// self-checking bench of sdl_top with the host model on the link
// assumes sdl_pkg compiled first; link period 320 ns, sys_clk 40 ns
`timescale 1ns/100ps
`default_nettype none

module tb;
    import sdl_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst_b   = 1'b0;
    sdl_ctrl_type ctrl    = 5'b11100;
    logic         cs_n;
    logic         sclk;
    logic         sdi;
    logic         sdo_out;
    logic         sdo_oe_n;
    logic [17:0]  dac_code;
    logic         code_is_binary;
    logic         clk_en  = 1'b1;
    logic         frame_buf_ready;
    logic         frame_done;
    logic         frame_short;
    logic         frame_dropped;
    int           done_seen  = 0;
    int           short_seen = 0;
    int           drop_seen  = 0;
    int           miscompares = 0;
    int           checks_done = 0;

    always #20 sys_clk = ~sys_clk;

    // pulse counters, sampled off the launching edge
    always @(negedge sys_clk) begin
        done_seen  <= done_seen + int'(frame_done);
        short_seen <= short_seen + int'(frame_short);
        drop_seen  <= drop_seen + int'(frame_dropped);
    end

    sdl_host u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out),
                     .sdo_oe_n(sdo_oe_n), .rx_word());

    sdl_top uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .hw_reset_n(ctrl.hw_reset_n),
        .reset_level_select(ctrl.reset_level_select),
        .code_format_select(ctrl.code_format_select),
        .readout_mode_select(ctrl.readout_mode_select),
        .latch_load_n(ctrl.latch_load_n), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .dac_code(dac_code),
        .code_is_binary(code_is_binary),
        .frame_buf_ready(frame_buf_ready), .frame_done(frame_done),
        .frame_short(frame_short), .frame_dropped(frame_dropped)
    );

    task automatic stop_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // frame then settle: dac_code lands 6 edges after cs_n rises
    task automatic frame(input logic [31:0] w, input int n);
        u_host.send(w, n);
        cyc(10);
    endtask

    initial begin
        #400000;
        miscompares++;
        stop_test();
    end

    initial begin
        cyc(16);
        check(dac_code, 18'h20000);
        rst_b = 1'b1;
        cyc(8);
        check(code_is_binary, 1'b1);
        check(sdo_oe_n, 1'b1);
        frame(32'h00FE5A5A, 24);
        check(dac_code, 18'h25A5A);
        frame(32'h00012345, 23);
        check(dac_code, 18'h25A5A);
        check(24'(short_seen), 24'h000001);
        frame(32'h0ABC1234, 28);
        check(dac_code, 18'h01234);
        ctrl.readout_mode_select = 1'b1;
        cyc(4);
        frame(32'h00C0ABCD, 24);
        check(u_host.rx_word, 24'h001234);
        check(dac_code, 18'h0ABCD);
        frame(32'h00000777, 20);
        check(dac_code, 18'h0ABCD);
        frame(32'h03FFFFF0, 28);
        check(u_host.rx_word, 24'h0ABCD0);
        ctrl.readout_mode_select = 1'b0;
        ctrl.latch_load_n = 1'b1;
        cyc(4);
        frame(32'h00015555, 24);
        check(u_host.rx_word, 24'hFFFFF0);
        check(dac_code, 18'h3FFF0);
        clk_en = 1'b0;
        ctrl.latch_load_n = 1'b0;
        cyc(6);
        check(dac_code, 18'h3FFF0);
        clk_en = 1'b1;
        cyc(6);
        check(dac_code, 18'h15555);
        ctrl.reset_level_select = 1'b0;
        ctrl.code_format_select = 1'b0;
        cyc(4);
        ctrl.hw_reset_n = 1'b0;
        cyc(6);
        check(dac_code, 18'h00000);
        check(code_is_binary, 1'b0);
        ctrl.hw_reset_n = 1'b1;
        cyc(6);
        check(dac_code, 18'h00000);
        frame(32'h00000003, 24);
        check(u_host.rx_word, 24'h015555);
        check(dac_code, 18'h00003);
        check(24'(done_seen), 24'h000006);
        check(24'(short_seen), 24'h000002);
        check(24'(drop_seen), 24'h000000);
        check(frame_buf_ready, 1'b1);
        stop_test();
    end
endmodule

`default_nettype wire
